// file: rtl/ssb_top.sv
// standby sense baseline: standby sensing sequencer and its registers
// assumes the converter delivers the selected input's count on raw_count_in
// on the same clock, and that power and calibration logic sit alongside
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defs.svh"

module ssb_top #(
    parameter int SAMP_UNIT_CYC  = `SSB_SAMP_UNIT_NS / `SSB_CLK_PERIOD_NS,
    parameter int CYCLE_UNIT_CYC = `SSB_CYCLE_UNIT_NS / `SSB_CLK_PERIOD_NS
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        standby_mode_in,
    input  wire logic        combo_mode_in,
    input  wire logic [2:0]  low_power_watch_in,
    input  wire logic        calib_run_in,
    input  wire logic [3:0]  base_shift_in,
    input  wire logic [15:0] raw_count_in,
    output logic             sample_req_out,
    output logic      [1:0]  sample_ch_out,
    output logic             low_power_out,
    output logic      [2:0]  touch_out
);

    // ======================================================================
    // registers
    logic [7:0] setup;
    logic [7:0] next_setup;
    logic [2:0] gain;
    logic [2:0] next_gain;
    logic [6:0] limit;
    logic [6:0] next_limit;
    logic [7:0] next_rdata;
    logic [7:0] base_view [3];

    always_comb begin
        next_setup = setup;
        next_gain  = gain;
        next_limit = limit;
        next_rdata = reg_rdata_out;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                `SSB_ADDR_SETUP: next_setup = reg_wdata_in;
                `SSB_ADDR_GAIN:  next_gain  = reg_wdata_in[`SSB_GAIN_MSB:0];
                `SSB_ADDR_LIMIT: next_limit = reg_wdata_in[`SSB_LIMIT_MSB:0];
                default: ;
            endcase
        end
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `SSB_ADDR_SETUP: next_rdata = setup;
                `SSB_ADDR_GAIN:  next_rdata = {5'h00, gain};
                `SSB_ADDR_LIMIT: next_rdata = {1'b0, limit};
                `SSB_ADDR_BASE1: next_rdata = base_view[0];
                `SSB_ADDR_BASE2: next_rdata = base_view[1];
                `SSB_ADDR_BASE3: next_rdata = base_view[2];
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            setup         <= `SSB_RST_SETUP;
            gain          <= 3'(`SSB_RST_GAIN);
            limit         <= 7'(`SSB_RST_LIMIT);
            reg_rdata_out <= 8'h00;
        end else begin
            setup         <= next_setup;
            gain          <= next_gain;
            limit         <= next_limit;
            reg_rdata_out <= next_rdata;
        end
    end

    // ======================================================================
    // decoded settings
    logic [31:0] samp_cycles;
    logic [31:0] cycle_cycles;
    logic [7:0]  samples;
    logic        sensing;

    assign samples      = 8'h01 << setup[`SSB_COUNT_MSB:`SSB_COUNT_LSB];
    assign samp_cycles  = 32'(SAMP_UNIT_CYC) << setup[`SSB_SPER_MSB:`SSB_SPER_LSB];
    // the add runs at full width; a two-bit sum would wrap code 3 to zero
    assign cycle_cycles = 32'(CYCLE_UNIT_CYC)
                        * (32'(setup[`SSB_CPER_MSB:`SSB_CPER_LSB]) + 32'h1);
    // combo state paces its cycle from the standby period as well
    assign sensing      = standby_mode_in || combo_mode_in;

    // first watched input at or above a start index
    function automatic logic [2:0] ssb_pick(input logic [2:0] mask, input logic [1:0] from);
        logic [2:0] res;
        res = 3'b000;
        for (int i = 2; i >= 0; i--) begin
            if (mask[i] && 2'(i) >= from) begin
                res = {1'b1, 2'(i)};
            end
        end
        return res;
    endfunction : ssb_pick

    // ======================================================================
    // sequencer
    ssb_pkg::ssb_state_t state;
    ssb_pkg::ssb_state_t next_state;
    logic [31:0] cycle_cnt;
    logic [31:0] next_cycle_cnt;
    logic [31:0] samp_cnt;
    logic [31:0] next_samp_cnt;
    logic [7:0]  takes_left;
    logic [7:0]  next_takes_left;
    logic [1:0]  next_ch;
    logic        next_req;
    logic        next_lowp;
    logic        take;
    logic        cyc_start;
    logic [2:0]  first_pick;
    logic [2:0]  later_pick;

    assign first_pick = ssb_pick(low_power_watch_in, 2'd0);
    assign later_pick = (sample_ch_out == 2'd2) ? 3'b000
                      : ssb_pick(low_power_watch_in, sample_ch_out + 2'd1);

    always_comb begin
        next_state      = state;
        next_cycle_cnt  = cycle_cnt + 32'h1;
        next_samp_cnt   = samp_cnt;
        next_takes_left = takes_left;
        next_ch         = sample_ch_out;
        next_req        = sample_req_out;
        next_lowp       = low_power_out;
        take            = 1'b0;
        cyc_start       = 1'b0;
        unique case (state)
            ssb_pkg::st_rest: begin
                next_lowp = sensing;
                if (!sensing) begin
                    // parked at the boundary so entry starts a cycle at once
                    next_cycle_cnt = cycle_cycles - 32'h1;
                end else if (cycle_cnt >= cycle_cycles - 32'h1) begin
                    cyc_start      = 1'b1;
                    next_cycle_cnt = 32'h0;
                    if (first_pick[2]) begin
                        next_state      = ssb_pkg::st_sample;
                        next_ch         = first_pick[1:0];
                        next_req        = 1'b1;
                        next_lowp       = 1'b0;
                        next_samp_cnt   = 32'h0;
                        next_takes_left = samples - 8'h01;
                    end
                end
            end
            ssb_pkg::st_sample: begin
                if (!sensing) begin
                    next_state = ssb_pkg::st_rest;
                    next_req   = 1'b0;
                end else if (samp_cnt == samp_cycles - 32'h1) begin
                    take          = 1'b1;
                    next_samp_cnt = 32'h0;
                    if (takes_left != 8'h00) begin
                        next_takes_left = takes_left - 8'h01;
                    end else if (later_pick[2]) begin
                        next_ch         = later_pick[1:0];
                        next_takes_left = samples - 8'h01;
                    end else begin
                        // remainder of the cycle is spent resting
                        next_state = ssb_pkg::st_rest;
                        next_req   = 1'b0;
                        next_lowp  = 1'b1;
                    end
                end else begin
                    next_samp_cnt = samp_cnt + 32'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state          <= ssb_pkg::st_rest;
            cycle_cnt      <= 32'h0;
            samp_cnt       <= 32'h0;
            takes_left     <= 8'h00;
            sample_ch_out  <= 2'd0;
            sample_req_out <= 1'b0;
            low_power_out  <= 1'b0;
        end else begin
            state          <= next_state;
            cycle_cnt      <= next_cycle_cnt;
            samp_cnt       <= next_samp_cnt;
            takes_left     <= next_takes_left;
            sample_ch_out  <= next_ch;
            sample_req_out <= next_req;
            low_power_out  <= next_lowp;
        end
    end

    // ======================================================================
    // per-input measurement and baseline
    for (genvar g = 0; g < 3; g++) begin : g_ch
        ssb_channel u_ch (
            .clk_in        (clk_in),
            .reset_n_in    (reset_n_in),
            .take_in       (take && sample_ch_out == 2'(g)),
            .last_in       (takes_left == 8'h00),
            .watch_in      (low_power_watch_in[g]),
            .calib_in      (calib_run_in),
            .reading_in    (raw_count_in),
            .acc_sel_in    (setup[`SSB_ACC_SEL_BIT]),
            .count_code_in (setup[`SSB_COUNT_MSB:`SSB_COUNT_LSB]),
            .gain_code_in  (gain),
            .limit_in      (limit),
            .base_shift_in (base_shift_in),
            .delta_out     (),
            .touch_out     (touch_out[g]),
            .baseline_out  (base_view[g])
        );
    end

    // ======================================================================
    // checks
    default clocking top_clk @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic [31:0] req_run;
    logic [7:0]  ch_takes;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in || !sample_req_out || take) begin
            req_run <= 32'h0;
        end else begin
            req_run <= req_run + 32'h1;
        end
        if (!reset_n_in || cyc_start) begin
            ch_takes <= 8'h00;
        end else if (take) begin
            ch_takes <= (takes_left == 8'h00) ? 8'h00 : ch_takes + 8'h01;
        end
    end

    // takes planned for the channel in hand; a count written mid-channel
    // only applies from the next channel, so the live code is no reference
    logic [7:0]  ch_plan;
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ch_plan <= 8'h00;
        end else if ((cyc_start && first_pick[2]) || (take && takes_left == 8'h00)) begin
            ch_plan <= samples - 8'h01;
        end
    end

    sequence s_cycle_idle;
        cyc_start && !first_pick[2];
    endsequence

    sequence s_setup_write_read;
        reg_write_in && reg_addr_in == `SSB_ADDR_SETUP ##1 !reg_write_in
            ##1 reg_read_in && !reg_write_in && reg_addr_in == `SSB_ADDR_SETUP;
    endsequence

    sequence s_last_take;
        take && takes_left == 8'h00;
    endsequence

    sequence s_switch;
        s_last_take ##1 sample_req_out;
    endsequence

    chk_gain_readback: assert property (reg_read_in && reg_addr_in == 8'h42 |=> reg_rdata_out[7:3] == 5'h00) else $error("gain upper bits not zero");
    chk_limit_readback: assert property (reg_read_in && reg_addr_in == 8'h43 |=> reg_rdata_out[7] == 1'b0) else $error("limit top bit not zero");
    chk_sample_time: assert property (take |-> req_run == samp_cycles - 32'h1) else $error("sample period wrong");
    chk_cycle_length: assert property (cyc_start && $past(sensing) && state == ssb_pkg::st_rest |-> $past(cycle_cnt) >= cycle_cycles - 32'h2) else $error("cycle started early");
    chk_cycle_samples: assert property (cyc_start && first_pick[2] |=> sample_req_out && !low_power_out && sample_ch_out == $past(first_pick[1:0])) else $error("cycle did not begin sampling");
    chk_take_count: assert property (s_last_take |-> ch_takes == ch_plan) else $error("channel left before all samples");
    chk_next_channel: assert property (s_switch |-> sample_ch_out > $past(sample_ch_out)) else $error("channel order broken");
    chk_rest_after: assert property (s_last_take ##0 (sensing && !later_pick[2]) |=> !sample_req_out && low_power_out) else $error("no rest after sampling");
    chk_watched_only: assert property ($rose(sample_req_out) |-> low_power_watch_in[sample_ch_out] || $changed(low_power_watch_in)) else $error("unwatched input sampled");
    chk_setup_read: assert property (s_setup_write_read |=> reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("setup write lost");
    chk_abort_idle: assert property (!sensing |=> !sample_req_out && !low_power_out)
        else $error("sensing not stopped");
    chk_none_watched: assert property (s_cycle_idle |=> low_power_out && !sample_req_out)
        else $error("idle cycle not resting");

endmodule : ssb_top
`default_nettype wire

// file: rtl/ssb_defs.svh
// standby sense baseline: register offsets, field positions, reset values, timing
// assumes a 100 MHz core clock and byte-wide register access
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

// ==========================================================================
// register offsets
`define SSB_ADDR_SETUP      8'h41
`define SSB_ADDR_GAIN       8'h42
`define SSB_ADDR_LIMIT      8'h43
`define SSB_ADDR_BASE1      8'h50
`define SSB_ADDR_BASE2      8'h51
`define SSB_ADDR_BASE3      8'h52

// ==========================================================================
// reset values
`define SSB_RST_SETUP       8'h39
`define SSB_RST_GAIN        8'h02
`define SSB_RST_LIMIT       8'h40
`define SSB_RST_BASE        16'h00c8

// ==========================================================================
// field positions
`define SSB_ACC_SEL_BIT     7
`define SSB_COUNT_MSB       6
`define SSB_COUNT_LSB       4
`define SSB_SPER_MSB        3
`define SSB_SPER_LSB        2
`define SSB_CPER_MSB        1
`define SSB_CPER_LSB        0
`define SSB_GAIN_MSB        2
`define SSB_LIMIT_MSB       6

// ==========================================================================
// timing
`define SSB_CLK_PERIOD_NS   10
`define SSB_SAMP_UNIT_NS    320000
`define SSB_CYCLE_UNIT_NS   35000000

// ==========================================================================
// arithmetic
`define SSB_CAL_SAMPLES_LOG2 8
`define SSB_GAIN_TOP_LOG2   7
`define SSB_DELTA_SHIFT     6

`endif

// file: rtl/ssb_pkg.sv
// standby sense baseline: shared types
// assumes nothing beyond the defs header for numbers
package ssb_pkg;

    // ======================================================================
    // sensing cycle sequencer
    typedef enum logic {
        st_rest,
        st_sample
    } ssb_state_t;

endpackage : ssb_pkg

// file: rtl/ssb_channel.sv
// standby sense baseline: one sensor input's delta, touch and baseline logic
// assumes take_in pulses once per finished sample, from the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defs.svh"

module ssb_channel (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        take_in,
    input  wire logic        last_in,
    input  wire logic        watch_in,
    input  wire logic        calib_in,
    input  wire logic [15:0] reading_in,
    input  wire logic        acc_sel_in,
    input  wire logic [2:0]  count_code_in,
    input  wire logic [2:0]  gain_code_in,
    input  wire logic [6:0]  limit_in,
    input  wire logic [3:0]  base_shift_in,
    output logic      [7:0]  delta_out,
    output logic             touch_out,
    output logic      [7:0]  baseline_out
);

    logic [22:0] meas_acc;
    logic [22:0] next_meas_acc;
    logic [23:0] base_acc;
    logic [23:0] next_base_acc;
    logic [7:0]  base_n;
    logic [7:0]  next_base_n;
    logic [15:0] baseline;
    logic [15:0] next_baseline;
    logic [7:0]  next_delta;
    logic        next_touch;
    logic [15:0] diff;
    logic [22:0] total;
    logic [22:0] value;
    logic [29:0] scaled;
    logic [23:0] base_sum;

    // ======================================================================
    // next values
    always_comb begin
        next_meas_acc = meas_acc;
        next_base_acc = base_acc;
        next_base_n   = base_n;
        next_baseline = baseline;
        next_delta    = delta_out;
        next_touch    = touch_out && watch_in;
        diff          = (reading_in > baseline) ? reading_in - baseline : 16'h0000;
        total         = meas_acc + {7'h00, diff};
        // sum mode wraps on purpose; average mode divides by the count
        value         = acc_sel_in ? total : (total >> count_code_in);
        scaled        = {value, 7'h00} >> (`SSB_DELTA_SHIFT + 32'(gain_code_in));
        base_sum      = base_acc + {8'h00, reading_in};
        if (take_in) begin
            if (last_in) begin
                next_meas_acc = 23'h000000;
                if (acc_sel_in) begin
                    next_delta = scaled[7:0];
                end else begin
                    next_delta = (|scaled[29:8]) ? 8'hff : scaled[7:0];
                end
                next_touch = watch_in && (next_delta > {1'b0, limit_in});
            end else begin
                next_meas_acc = total;
            end
            if (calib_in) begin
                next_base_acc = base_sum;
                next_base_n   = base_n + 8'h01;
                if (base_n == 8'hff) begin
                    next_baseline = base_sum[23:`SSB_CAL_SAMPLES_LOG2];
                    next_base_acc = 24'h000000;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            meas_acc  <= 23'h000000;
            base_acc  <= 24'h000000;
            base_n    <= 8'h00;
            baseline  <= `SSB_RST_BASE;
            delta_out <= 8'h00;
            touch_out <= 1'b0;
        end else begin
            meas_acc  <= next_meas_acc;
            base_acc  <= next_base_acc;
            base_n    <= next_base_n;
            baseline  <= next_baseline;
            delta_out <= next_delta;
            touch_out <= next_touch;
        end
    end

    // window into the 16-bit baseline chosen by the shift control
    assign baseline_out = 8'(baseline >> base_shift_in);

    // ======================================================================
    // checks
    default clocking ch_clk @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    chk_touch_compare: assert property (take_in && last_in |=> touch_out == (watch_in && (delta_out > {1'b0, limit_in}))) else $error("touch flag disagrees with limit");
    chk_base_update: assert property (take_in && calib_in && base_n == 8'hff |=> base_acc == 24'h000000 && baseline == $past(base_sum[23:8])) else $error("baseline not refreshed");

endmodule : ssb_channel
`default_nettype wire

// file: dv/ssb_pad_model.sv
// sensor pad stand-in: one count per input, shown while sampled
// assumes the sequencer holds the input index for a whole sample
`timescale 1ns/1ps
`default_nettype none

module ssb_pad_model (
    input  wire logic        clk_in,
    input  wire logic        req_in,
    input  wire logic [1:0]  ch_in,
    input  wire logic [47:0] level_in,
    output logic      [15:0] count_out
);
    // =====================================
    // released line
    logic [15:0] last = 16'h0000;
    logic [15:0] now;

    assign now = level_in[{ch_in, 4'h0} +: 16];

    always_ff @(posedge clk_in) begin
        if (req_in) begin
            last <= now;
        end
    end

    // idle shows the inverse, so a late sample never matches by luck
    assign count_out = req_in ? now : ~last;
endmodule : ssb_pad_model

`default_nettype wire

// file: dv/testbench.sv
// bench: register port and standby sensing, shortened time units
// assumes stimulus on the falling edge, pads from ssb_pad_model
`timescale 1ns/1ps
`default_nettype none
`include "ssb_defs.svh"

module testbench;
    localparam int SU = 4;
    localparam int CU = 200;
    logic        clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic        wr = 1'b0, rd = 1'b0, stby = 1'b0, combo = 1'b0;
    logic        calib = 1'b0, req, lowp;
    logic [2:0]  watch = 3'h0, touch, tch;
    logic [3:0]  shift = 4'h0;
    logic [47:0] level = 48'h0;
    logic [15:0] raw;
    logic [1:0]  ch;
    int          failures = 0, tests_run = 0, span, desc, lp, need, per;
    int          hi [3];
    logic [7:0]  ra [7] = '{8'h41, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h44};
    logic [7:0]  rv [7] = '{8'h39, 8'h02, 8'h40, 8'hc8, 8'hc8, 8'hc8, 8'h00};

    ssb_top #(.SAMP_UNIT_CYC(SU), .CYCLE_UNIT_CYC(CU)) dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata), .standby_mode_in(stby), .combo_mode_in(combo),
        .low_power_watch_in(watch), .calib_run_in(calib), .base_shift_in(shift),
        .raw_count_in(raw), .sample_req_out(req), .sample_ch_out(ch),
        .low_power_out(lowp), .touch_out(touch));

    ssb_pad_model pad_u (.clk_in(clk_in), .req_in(req), .ch_in(ch),
        .level_in(level), .count_out(raw));

    always #5 clk_in = ~clk_in;

    // =====================================
    // shared tasks
    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, d);
        @(negedge clk_in);
        addr = a; wdata = d; wr = 1'b1;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : reg_write

    task automatic reg_expect(input logic [7:0] a, e);
        @(negedge clk_in);
        addr = a; rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        check($sformatf("reg %h", a), rdata, e);
    endtask : reg_expect

    // skips any cycle in progress, then follows one whole cycle
    task automatic sense();
        int n, pch;
        logic gone;
        n = 0; pch = 0; gone = 1'b0; hi = '{0, 0, 0}; desc = 0; span = 0; lp = 0;
        while (req === 1'b1 && n < 9000) begin @(negedge clk_in); n++; end
        while (req !== 1'b1 && n < 9000) begin @(negedge clk_in); n++; end
        while (!(gone && req === 1'b1) && n < 9000) begin
            if (req === 1'b1) begin
                hi[ch] += 1;
                if (int'(ch) < pch) desc++;
                pch = int'(ch);
            end else gone = 1'b1;
            if (lowp === 1'b1) lp++;
            @(negedge clk_in);
            span++; n++;
        end
        check("sense done", n < 9000, 1);
        tch = touch;
    endtask : sense

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge clk_in);
        failures++;
        tally_and_finish();
    end

    // =====================================
    // scenarios
    initial begin
        repeat (10) @(negedge clk_in);
        reset_n_in = 1'b1;
        for (int i = 0; i < 7; i++) reg_expect(ra[i], rv[i]);
        reg_write(8'h42, 8'hff);
        reg_expect(8'h42, 8'h07);
        reg_write(8'h43, 8'hff);
        reg_expect(8'h43, 8'h7f);
        reg_write(8'h50, 8'h00);
        reg_expect(8'h50, 8'hc8);
        // two samples, shortest period and cycle, 64x gain
        reg_write(8'h41, 8'h10);
        reg_expect(8'h41, 8'h10);
        reg_write(8'h42, 8'h01);
        reg_write(8'h43, 8'h40);
        level = {16'h00f8, 16'hffff, 16'h0118};
        watch = 3'b101;
        stby = 1'b1;
        sense();
        check("input 1 samples", hi[0], 2 * SU);
        check("unwatched samples", hi[1], 0);
        check("input 3 samples", hi[2], 2 * SU);
        check("ascending", desc, 0);
        check("cycle span", span, CU);
        check("rest seen", lp > 0, 1);
        check("avg touch", tch, 3'b001);
        // sum kept to two small samples, far from overflow
        reg_write(8'h41, 8'h90);
        sense();
        check("sum touch", tch, 3'b101);
        // one sample; delta 40h scaled by each gain against limit 3fh
        reg_write(8'h41, 8'h00);
        reg_write(8'h43, 8'h3f);
        level[15:0] = 16'h0108;
        watch = 3'b001;
        for (int g = 0; g < 8; g++) begin
            reg_write(8'h42, 8'(g));
            sense();
            sense();
            check("gain touch", tch[0], (128 >> g) > 63);
            check("unwatched touch", tch[2:1], 2'b00);
        end
        for (int k = 0; k < 8; k++) begin
            reg_write(8'h41, {1'b0, 3'(k), 2'(k % 4), 2'(k % 4)});
            sense();
            need = (1 << k) * (SU << (k % 4));
            per = CU * (k % 4 + 1);
            check("sample cycles", hi[0], need);
            if (need < per) check("period", span, per);
            else check("stretched", span >= need && span <= need + 4, 1);
        end
        stby = 1'b0;
        reg_write(8'h41, 8'h01);
        check("stop idle", {req, lowp}, 2'b00);
        combo = 1'b1;
        sense();
        check("combo span", span, 2 * CU);
        watch = 3'b000;
        repeat (3 * CU) @(negedge clk_in);
        check("none watched", {req, lowp}, 2'b01);
        watch = 3'b001;
        reg_write(8'h41, 8'h70);
        level[15:0] = 16'h1234;
        calib = 1'b1;
        sense();
        sense();
        calib = 1'b0;
        reg_expect(8'h50, 8'h34);
        shift = 4'h4;
        reg_expect(8'h50, 8'h23);
        reg_expect(8'h51, 8'h0c);
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
